// File: led_diag_cfg.svh
// constants for the diagnostic and sleep instruction decoder
// assumes a 200 mhz system clock; included by the package and the top
`ifndef LED_DIAG_CFG_SVH
`define LED_DIAG_CFG_SVH
`define CH_COUNT    16
`define CNT_W       5
`define CNT_RESET   5'h00
`define CNT_MAX     5'h1f
`define CNT_OPEN    5'h02
`define CNT_SHORT   5'h04
`define CNT_GND     5'h06
`define CNT_SMART   5'h0a
`define CNT_SLEEP   5'h0c
`define CNT_CURRENT_SET_RESISTOR_PIN    5'h0e
`define CLK_MHZ     200
`define WD_TIME_MS  30
`define WD_CYCLES   (`WD_TIME_MS * 1000 * `CLK_MHZ)
`define WD_W        23
`define FIFO_DEPTH  16
`define WORD_RESET  16'hffff
`define CURRENT_SET_RESISTOR_PIN_FILL   14'h3fff
`define THR_RESET   2'h0
`endif

// File: led_diag_pkg.sv
// types shared by the instruction decoder
// assumes led_diag_cfg.svh is on the include path
package led_diag_pkg;
`include "led_diag_cfg.svh"
  // decoder progress in the system domain
  typedef enum logic [1:0] {ST_IDLE, ST_COUNT, ST_DETECT, ST_PUSH} sys_state_t;
  // which detection is running
  typedef enum logic [2:0] {
    MODE_NONE, MODE_OPEN, MODE_SHORT, MODE_GND, MODE_SMART, MODE_CURRENT_SET_RESISTOR_PIN
  } diag_mode_t;
  // whole system-domain state
  typedef struct packed {
    logic [2:0]           lat_sy;
    logic [2:0]           di_sy;
    logic [2:0]           gck_sy;
    logic                 wden_m;
    logic                 wden_s;
    logic [1:0]           thr_m;
    logic [1:0]           thr_s;
    logic [`CH_COUNT-1:0] below_m;
    logic [`CH_COUNT-1:0] below_s;
    logic [`CH_COUNT-1:0] above_m;
    logic [`CH_COUNT-1:0] above_s;
    logic [2:0]           current_set_resistor_pin_m;
    logic [2:0]           current_set_resistor_pin_s;
    logic [2:0]           cap_sy;
    logic                 ack_m;
    logic                 ack_s;
    sys_state_t           state;
    diag_mode_t           mode;
    logic [`CNT_W-1:0]    count;
    logic [`WD_W-1:0]     wd_cnt;
    logic                 sleep;
    logic                 test_en;
    logic                 force_off;
    logic [`CH_COUNT-1:0] word;
    logic                 req;
    logic [`CH_COUNT-1:0] xfer_word;
  } sys_t;
  // whole shift-clock-domain state
  typedef struct packed {
    logic [`CH_COUNT-1:0] sr;
    logic                 dout;
    logic                 lat_d;
    logic                 cap_t;
    logic                 req_m;
    logic                 req_s;
    logic                 ack;
  } link_t;
endpackage

// File: diag_result_fifo.sv
// single-clock fifo holding result words on their way to the link
// assumes both sides run on the system clock and hold valid until ready
`timescale 1ns/1ps
module diag_result_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam int PW = AW + 1;
  // pointers carry one wrap bit to tell full from empty
  typedef struct packed {
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
  } fifo_state_t;

  fifo_state_t    f_reg;            // registered pointers
  fifo_state_t    f_next;           // next pointers
  logic [WIDTH-1:0] mem [DEPTH];    // word storage
  logic           push;             // accepted write
  logic           pop;              // accepted read

  // full when the addresses meet with opposite wrap bits
  assign in_ready  = !((f_reg.wr_ptr[AW] != f_reg.rd_ptr[AW]) &&
                       (f_reg.wr_ptr[AW-1:0] == f_reg.rd_ptr[AW-1:0]));
  assign out_valid = (f_reg.wr_ptr != f_reg.rd_ptr);
  assign out_data  = mem[f_reg.rd_ptr[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // pointer advance
  always_comb begin
    f_next = f_reg;
    if (push) begin
      f_next.wr_ptr = f_reg.wr_ptr + PW'(1);
    end
    if (pop) begin
      f_next.rd_ptr = f_reg.rd_ptr + PW'(1);
    end
  end

  // storage has no reset; only written words are ever read
  always_ff @(posedge clock) begin
    if (push) begin
      mem[f_reg.wr_ptr[AW-1:0]] <= in_data;
    end
  end

  // pointer registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      f_reg <= '0;
    end else begin
      f_reg <= f_next;
    end
  end
endmodule

// File: led_diag_decoder.sv
// diagnostic, sleep and readout instruction decoder of the led sink
// assumes shift_clock, latch_strobe and serial_data_in launch together
// from the controller; comparator levels arrive unsynchronised
// Function
// - pulse counts 2, 4, 6 select open/short/gnd
// - combined detection turns all outputs on at test current
// - window ends at first shift clock after fall
// - low or over-threshold channel loads a zero
// - healthy channel loads a one
// - result bits leave on each rising shift clock edge
// - latch high: output is retimed input
// - sleep at strobe fall, wake at next fall of any other instruction
// - serial path keeps shifting during sleep
// - resistor open, high or low is error
// - resistor bit first, watchdog bit last, ones between
// - enabled watchdog reports zero after 30 ms stall
`timescale 1ns/1ps
`include "led_diag_cfg.svh"
module led_diag_decoder #(
  parameter int unsigned WD_CYCLES = `WD_CYCLES
) (
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  input  wire logic                 shift_clock,
  input  wire logic                 latch_strobe,
  input  wire logic                 serial_data_in,
  input  wire logic                 grayscale_clock,
  input  wire logic                 watchdog_enable,
  input  wire logic [1:0]           short_threshold_cmd,
  input  wire logic [`CH_COUNT-1:0] channel_below_open,
  input  wire logic [`CH_COUNT-1:0] channel_above_short,
  input  wire logic                 current_set_resistor_pin_open,
  input  wire logic                 current_set_resistor_pin_high,
  input  wire logic                 current_set_resistor_pin_low,
  output logic                      serial_data_out,
  output logic                      test_current_enable,
  output logic                      channel_force_off,
  output logic                      sleep_mode,
  output logic [1:0]                short_threshold_select
);
  import led_diag_pkg::*;

  localparam logic [`WD_W-1:0] WD_LIMIT = `WD_W'(WD_CYCLES);

  sys_t                 s_reg;       // system-domain state
  sys_t                 s_next;      // its next value
  link_t                l_reg;       // shift-clock-domain state
  link_t                l_next;      // its next value
  logic                 lat_rise;    // strobe rose, system view
  logic                 lat_fall;    // strobe fell, system view
  logic                 di_rise;     // one data pulse counted
  logic                 gck_edge;    // grayscale clock toggled
  logic                 cap_edge;    // capture edge reached system
  logic                 wd_ok;       // watchdog result bit
  logic                 current_set_resistor_pin_err;    // resistor pin fault
  logic [`CH_COUNT-1:0] smart_bits;  // combined open/short result
  logic                 fifo_ready;  // fifo can take a word
  logic                 fifo_valid;  // fifo has a word
  logic [`CH_COUNT-1:0] fifo_data;   // head word
  logic                 xfer_idle;   // link took the last word
  logic                 link_load;   // load edge in link domain

  // edges seen on the second synchroniser stage and its delay
  assign lat_rise   = s_reg.lat_sy[1] && !s_reg.lat_sy[2];
  assign lat_fall   = !s_reg.lat_sy[1] && s_reg.lat_sy[2];
  assign di_rise    = s_reg.di_sy[1] && !s_reg.di_sy[2];
  assign gck_edge   = s_reg.gck_sy[1] != s_reg.gck_sy[2];
  assign cap_edge   = s_reg.cap_sy[1] != s_reg.cap_sy[2];
  // a stalled grayscale clock only counts when enabled
  assign wd_ok      = !(s_reg.wden_s && s_reg.wd_cnt == WD_LIMIT);
  assign current_set_resistor_pin_err   = |s_reg.current_set_resistor_pin_s;
  assign smart_bits = ~(s_reg.below_s | s_reg.above_s);
  assign xfer_idle  = s_reg.req == s_reg.ack_s;
  assign link_load  = l_reg.req_s != l_reg.ack;

  // outputs straight from state flops
  assign test_current_enable    = s_reg.test_en;
  assign channel_force_off      = s_reg.force_off;
  assign sleep_mode             = s_reg.sleep;
  assign short_threshold_select = s_reg.thr_s;
  assign serial_data_out        = l_reg.dout;

  // result words queue here; a full queue stalls the decoder
  diag_result_fifo #(
    .WIDTH (`CH_COUNT),
    .DEPTH (`FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .rst_n     (rst_n),
    .in_valid  (s_reg.state == ST_PUSH),
    .in_ready  (fifo_ready),
    .in_data   (s_reg.word),
    .out_valid (fifo_valid),
    .out_ready (xfer_idle),
    .out_data  (fifo_data)
  );

  // system domain: synchronise, count, decode, watchdog
  always_comb begin
    s_next = s_reg;
    // two-stage synchronisers, third stage only for edges
    s_next.lat_sy  = {s_reg.lat_sy[1:0], latch_strobe};
    s_next.di_sy   = {s_reg.di_sy[1:0], serial_data_in};
    s_next.gck_sy  = {s_reg.gck_sy[1:0], grayscale_clock};
    s_next.cap_sy  = {s_reg.cap_sy[1:0], l_reg.cap_t};
    s_next.wden_m  = watchdog_enable;
    s_next.wden_s  = s_reg.wden_m;
    s_next.thr_m   = short_threshold_cmd;
    s_next.thr_s   = s_reg.thr_m;
    s_next.below_m = channel_below_open;
    s_next.below_s = s_reg.below_m;
    s_next.above_m = channel_above_short;
    s_next.above_s = s_reg.above_m;
    s_next.current_set_resistor_pin_m  = {current_set_resistor_pin_open, current_set_resistor_pin_high, current_set_resistor_pin_low};
    s_next.current_set_resistor_pin_s  = s_reg.current_set_resistor_pin_m;
    s_next.ack_m   = l_reg.ack;
    s_next.ack_s   = s_reg.ack_m;
    // stall timer restarts on any grayscale edge
    if (gck_edge) begin
      s_next.wd_cnt = '0;
    end else if (s_reg.wd_cnt != WD_LIMIT) begin
      s_next.wd_cnt = s_reg.wd_cnt + `WD_W'(1);
    end
    unique case (s_reg.state)
      ST_IDLE: begin
        if (lat_rise) begin
          s_next.count = `CNT_RESET;
          s_next.state = ST_COUNT;
        end
      end
      ST_COUNT: begin
        // saturate so a runaway burst never aliases a command
        if (di_rise && s_reg.count != `CNT_MAX) begin
          s_next.count = s_reg.count + `CNT_W'(1);
        end
        if (lat_fall) begin
          s_next.state = ST_IDLE;
          s_next.mode  = MODE_NONE;
          s_next.sleep = 1'h0;
          unique case (s_reg.count)
            `CNT_OPEN: begin
              s_next.mode    = MODE_OPEN;
              s_next.test_en = 1'h1;
              s_next.state   = ST_DETECT;
            end
            `CNT_SHORT: begin
              s_next.mode    = MODE_SHORT;
              s_next.test_en = 1'h1;
              s_next.state   = ST_DETECT;
            end
            `CNT_GND: begin
              // outputs off so leakage pulls the pin low
              s_next.mode      = MODE_GND;
              s_next.force_off = 1'h1;
              s_next.state     = ST_DETECT;
            end
            `CNT_SMART: begin
              s_next.mode    = MODE_SMART;
              s_next.test_en = 1'h1;
              s_next.state   = ST_DETECT;
            end
            `CNT_SLEEP: begin
              s_next.sleep = 1'h1;
            end
            `CNT_CURRENT_SET_RESISTOR_PIN: begin
              // no window needed, pin level is static
              s_next.mode  = MODE_CURRENT_SET_RESISTOR_PIN;
              s_next.word  = {!current_set_resistor_pin_err, `CURRENT_SET_RESISTOR_PIN_FILL, wd_ok};
              s_next.state = ST_PUSH;
            end
            default: begin
              // any other count is not a diagnostic instruction
              s_next.mode = MODE_NONE;
            end
          endcase
        end
      end
      ST_DETECT: begin
        // window closes at the first shift edge after the fall
        if (cap_edge) begin
          s_next.test_en   = 1'h0;
          s_next.force_off = 1'h0;
          s_next.state     = ST_PUSH;
          unique case (s_reg.mode)
            MODE_SHORT: s_next.word = ~s_reg.above_s;
            MODE_SMART: s_next.word = smart_bits;
            default:    s_next.word = ~s_reg.below_s;
          endcase
        end else if (lat_rise) begin
          // a new instruction abandons an unfinished window
          s_next.test_en   = 1'h0;
          s_next.force_off = 1'h0;
          s_next.count     = `CNT_RESET;
          s_next.state     = ST_COUNT;
        end
      end
      ST_PUSH: begin
        if (fifo_ready) begin
          s_next.state = ST_IDLE;
        end
      end
    endcase
    // hand the head word to the link, held until acknowledged
    if (fifo_valid && xfer_idle) begin
      s_next.xfer_word = fifo_data;
      s_next.req       = !s_reg.req;
    end
  end

  // system registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_reg           <= '0;
      s_reg.state     <= ST_IDLE;
      s_reg.mode      <= MODE_NONE;
      s_reg.word      <= `WORD_RESET;
      s_reg.xfer_word <= `WORD_RESET;
      s_reg.thr_s     <= `THR_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // link domain: strobe and data are launched on this clock, so
  // they are read without synchronisers; sleep never stops it
  always_comb begin
    l_next       = l_reg;
    l_next.req_m = s_reg.req;
    l_next.req_s = l_reg.req_m;
    l_next.lat_d = latch_strobe;
    // first edge with strobe low after it was high
    if (l_reg.lat_d && !latch_strobe) begin
      l_next.cap_t = !l_reg.cap_t;
    end
    // retimed data while latched, else shift-register tail
    if (latch_strobe) begin
      l_next.dout = serial_data_in;
    end else begin
      l_next.dout = l_reg.sr[`CH_COUNT-1];
    end
    if (link_load) begin
      l_next.sr  = s_reg.xfer_word;
      l_next.ack = l_reg.req_s;
    end else begin
      l_next.sr = {l_reg.sr[`CH_COUNT-2:0], serial_data_in};
    end
  end

  // link registers
  always_ff @(posedge shift_clock or negedge rst_n) begin
    if (!rst_n) begin
      l_reg    <= '0;
      l_reg.sr <= `WORD_RESET;
    end else begin
      l_reg <= l_next;
    end
  end

  // checks, system domain
  sequence q_lat_fall;
    !s_reg.lat_sy[1] && s_reg.lat_sy[2] && s_reg.state == ST_COUNT;
  endsequence

  sequence q_decode(logic [`CNT_W-1:0] n);
    q_lat_fall ##0 (s_reg.count == n);
  endsequence

  property p_count_clear;
    @(posedge clock) disable iff (!rst_n)
    (lat_rise && s_reg.state == ST_IDLE) |=>
      (s_reg.count == `CNT_RESET) && (s_reg.state == ST_COUNT);
  endproperty
  a_count_clear: assert property (p_count_clear)
    else $error("pulse count not cleared at strobe rise");

  property p_open_decode;
    @(posedge clock) disable iff (!rst_n)
    q_decode(`CNT_OPEN) |=>
      test_current_enable && s_reg.mode == MODE_OPEN &&
      s_reg.state == ST_DETECT;
  endproperty
  a_open_decode: assert property (p_open_decode)
    else $error("open detection not started");

  property p_gnd_decode;
    @(posedge clock) disable iff (!rst_n)
    q_decode(`CNT_GND) |=> channel_force_off && !test_current_enable;
  endproperty
  a_gnd_decode: assert property (p_gnd_decode)
    else $error("ground detection did not force outputs off");

  property p_smart_current;
    @(posedge clock) disable iff (!rst_n)
    q_decode(`CNT_SMART) |=> test_current_enable ##0
      (s_reg.mode == MODE_SMART);
  endproperty
  a_smart_current: assert property (p_smart_current)
    else $error("combined detection without test current");

  property p_window_hold;
    @(posedge clock) disable iff (!rst_n)
    (test_current_enable && s_reg.state == ST_DETECT && !cap_edge &&
     !lat_rise) |=> test_current_enable;
  endproperty
  a_window_hold: assert property (p_window_hold)
    else $error("test current dropped before capture edge");

  property p_smart_word;
    @(posedge clock) disable iff (!rst_n)
    (s_reg.state == ST_DETECT && s_reg.mode == MODE_SMART && cap_edge)
      |=> (s_reg.word == $past(smart_bits)) && !test_current_enable;
  endproperty
  a_smart_word: assert property (p_smart_word)
    else $error("combined detection word wrong");

  property p_sleep_enter;
    @(posedge clock) disable iff (!rst_n)
    q_decode(`CNT_SLEEP) |=> sleep_mode [*2];
  endproperty
  a_sleep_enter: assert property (p_sleep_enter)
    else $error("sleep not entered at strobe fall");

  property p_wake;
    @(posedge clock) disable iff (!rst_n)
    (sleep_mode && lat_fall && s_reg.state == ST_COUNT &&
     s_reg.count != `CNT_SLEEP) |=> !sleep_mode;
  endproperty
  a_wake: assert property (p_wake)
    else $error("sleep not left at next strobe fall");

  property p_current_set_resistor_pin_word;
    @(posedge clock) disable iff (!rst_n)
    q_decode(`CNT_CURRENT_SET_RESISTOR_PIN) |=> (s_reg.word[14:1] == `CURRENT_SET_RESISTOR_PIN_FILL) &&
      (s_reg.word[15] == !$past(current_set_resistor_pin_err)) &&
      (s_reg.word[0] == $past(wd_ok)) && (s_reg.state == ST_PUSH);
  endproperty
  a_current_set_resistor_pin_word: assert property (p_current_set_resistor_pin_word)
    else $error("resistor readout word wrong");

  property p_wd_restart;
    @(posedge clock) disable iff (!rst_n)
    gck_edge |=> (s_reg.wd_cnt == '0) ##0 wd_ok;
  endproperty
  a_wd_restart: assert property (p_wd_restart)
    else $error("watchdog not restarted by grayscale edge");

  // checks, link domain
  property p_retime;
    @(posedge shift_clock) disable iff (!rst_n)
    latch_strobe |=> serial_data_out == $past(serial_data_in);
  endproperty
  a_retime: assert property (p_retime)
    else $error("data out is not retimed data in");

  property p_shift;
    @(posedge shift_clock) disable iff (!rst_n)
    (!latch_strobe && !link_load) |=>
      (serial_data_out == $past(l_reg.sr[15])) &&
      (l_reg.sr[15:1] == $past(l_reg.sr[14:0]));
  endproperty
  a_shift: assert property (p_shift)
    else $error("shift register did not advance");
endmodule

// File: led_ctrl_model.sv
// display controller model for the far side of the serial chain
// assumes the decoder samples the link on rising shift_clock edges
`timescale 1ns/1ps
module led_ctrl_model (
  output logic      shift_clock,
  output logic      latch_strobe,
  output logic      serial_data_in,
  input  wire logic serial_data_out
);
  logic retime_ok;  // cleared when the cascade copy goes wrong
  logic lat_prev;   // latch level at the previous link edge
  // link clock rests low outside frames
  initial begin
    shift_clock = 1'b0;
    latch_strobe = 1'b0;
    serial_data_in = 1'b0;
    retime_ok = 1'b1;
    lat_prev = 1'b0;
  end
  // one 32 ns link period; new levels launched 2 ns after the rise
  task automatic step(input logic l, input logic d);
    logic hi;
    logic dp;
    hi = latch_strobe & lat_prev;
    dp = serial_data_in;
    shift_clock = 1'b1;
    #1;
    // out must copy the bit taken at this edge
    if (hi && serial_data_out !== dp) retime_ok = 1'b0;
    #1;
    lat_prev = latch_strobe;
    latch_strobe = l;
    serial_data_in = d;
    #14;
    shift_clock = 1'b0;
    #16;
  endtask
  // whole instruction: latch up, n data pulses, latch down
  task automatic frame(input int n);
    latch_strobe = 1'b1;  // rise clears the count
    serial_data_in = 1'b0;
    #16;
    // pulse count picks the instruction
    repeat (n) begin
      step(1'b1, 1'b1);
      step(1'b1, 1'b0);
    end
    step(1'b0, 1'b0);  // fall decodes the count; detection counts open their window
  endtask
  // 48 idle edges feeding a repeated pattern, out collected msb first
  task automatic read_bits(input logic [15:0] pat, output logic [47:0] s);
    int i;
    s = '0;
    for (i = 0; i < 48; i++) begin
      step(1'b0, pat[15 - i % 16]);
      s = {s[46:0], serial_data_out};
    end
  endtask
endmodule

// File: led_diag_sleep_instructions_tb.sv
// self-checking bench for the diagnostic and sleep decoder
// assumes led_ctrl_model drives the link; watchdog count shortened
`timescale 1ns/1ps
`define CHK(n, e, g) check(n, 48'(e), 48'(g))
module led_diag_sleep_instructions_tb;
  import led_diag_pkg::*;
  localparam int unsigned WD = 200;  // short watchdog for simulation
  logic        clock, rst_n, grayscale_clock, gck_run, watchdog_enable;
  logic        shift_clock, latch_strobe, serial_data_in, serial_data_out;
  logic        current_set_resistor_pin_open, current_set_resistor_pin_high, current_set_resistor_pin_low, sleep_mode;
  logic        test_current_enable, channel_force_off;
  logic [1:0]  short_threshold_cmd, short_threshold_select;
  logic [15:0] channel_below_open, channel_above_short;
  int          fails, n_compared;
  led_diag_decoder #(.WD_CYCLES(WD)) u_led_diag_decoder (
    .clock(clock), .rst_n(rst_n), .shift_clock(shift_clock),
    .latch_strobe(latch_strobe), .serial_data_in(serial_data_in),
    .grayscale_clock(grayscale_clock), .watchdog_enable(watchdog_enable),
    .short_threshold_cmd(short_threshold_cmd),
    .channel_below_open(channel_below_open),
    .channel_above_short(channel_above_short), .current_set_resistor_pin_open(current_set_resistor_pin_open),
    .current_set_resistor_pin_high(current_set_resistor_pin_high), .current_set_resistor_pin_low(current_set_resistor_pin_low),
    .serial_data_out(serial_data_out),
    .test_current_enable(test_current_enable),
    .channel_force_off(channel_force_off), .sleep_mode(sleep_mode),
    .short_threshold_select(short_threshold_select));
  led_ctrl_model u_led_ctrl_model (
    .shift_clock(shift_clock), .latch_strobe(latch_strobe),
    .serial_data_in(serial_data_in), .serial_data_out(serial_data_out));
  // 200 mhz system clock
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // free grayscale clock, 80 ns period, stoppable for stalls
  always #40 if (gck_run) grayscale_clock = ~grayscale_clock;
  task automatic check(input string n, input logic [47:0] e, g);
    n_compared++;
    if (e !== g) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // 0 test current, 1 forced off, 2 sleep
  function automatic logic sel(input int k);
    case (k)
      0: return test_current_enable;
      1: return channel_force_off;
      default: return sleep_mode;
    endcase
  endfunction
  // bounded wait for a status output, then judge it
  task automatic wait_out(input int k, input logic v);
    int i;
    i = 0;
    while (i < 40 && sel(k) !== v) begin
      @(posedge clock);
      #1;
      i++;
    end
    if (sel(k) !== v) begin
      // a flag that never settles is a mismatch and ends the run
      fails++;
      $display("ERROR flag_timeout expected %h seen %h", v, sel(k));
      complete_run();
    end
    else `CHK("flag", v, sel(k));
  endtask
  // true where w sits as 16 straight bits in the stream
  function automatic logic found(input logic [47:0] s, input logic [15:0] w);
    int i;
    found = 1'b0;
    for (i = 0; i <= 32; i++)
      if (s[i +: 16] === w) found = 1'b1;
  endfunction
  // one detection instruction, window, capture and readout
  task automatic t_detect(input int n, input logic [15:0] w);
    logic [47:0] s;
    u_led_ctrl_model.frame(n);
    wait_out(n == 6, 1'b1);
    `CHK("test", n != 6, test_current_enable);
    `CHK("force", n == 6, channel_force_off);
    u_led_ctrl_model.step(1'b0, 1'b0);
    wait_out(n == 6, 1'b0);  // first edge ends the window
    u_led_ctrl_model.read_bits(16'h0000, s);
    `CHK("word", 1'b1, found(s, w));
  endtask
  // sleep entry, shifting while asleep, repeat, wake
  task automatic t_sleep();
    logic [47:0] s;
    gck_run = 1'b0;
    grayscale_clock = 1'b1;  // held high while asleep
    u_led_ctrl_model.frame(12);
    wait_out(2, 1'b1);
    u_led_ctrl_model.read_bits(16'hc35a, s);
    `CHK("sleep_shift", 1'b1, found(s, 16'hc35a));
    u_led_ctrl_model.frame(12);
    wait_out(2, 1'b1);
    u_led_ctrl_model.frame(3);
    wait_out(2, 1'b0);  // a fall with any count but 12 wakes
    gck_run = 1'b1;
  endtask
  // resistor faults one by one, then watchdog stall on and off
  task automatic t_current_set_resistor_pin();
    logic [47:0] s;
    logic [15:0] w;
    int k;
    for (k = 0; k < 6; k++) begin
      @(posedge clock);
      #1;
      watchdog_enable = (k != 5);
      {current_set_resistor_pin_open, current_set_resistor_pin_high, current_set_resistor_pin_low} = 3'b100 >> (k - 1);
      gck_run = (k < 4);
      repeat (k >= 4 ? WD + 60 : 4) @(posedge clock);
      w = (k == 4) ? 16'hfffe : (k == 0 || k == 5) ? 16'hffff : 16'h7fff;
      u_led_ctrl_model.frame(14);
      u_led_ctrl_model.read_bits(16'h0000, s);
      `CHK("current_set_resistor_pin_word", 1'b1, found(s, w));
    end
    gck_run = 1'b1;
  endtask
  // reset, then every scenario in turn
  initial begin
    fails = 0;
    n_compared = 0;
    rst_n = 1'b0;
    grayscale_clock = 1'b0;
    gck_run = 1'b1;
    watchdog_enable = 1'b0;
    short_threshold_cmd = 2'h2;
    channel_below_open = 16'h0013;
    channel_above_short = 16'h8400;
    {current_set_resistor_pin_open, current_set_resistor_pin_high, current_set_resistor_pin_low} = 3'h0;
    repeat (6) @(posedge clock);
    #1 rst_n = 1'b1;
    repeat (10) @(posedge clock);
    #1;
    `CHK("thr", 2'h2, short_threshold_select);
    t_detect(2, 16'hffec);
    t_detect(4, 16'h7bff);
    t_detect(6, 16'hffec);
    t_detect(10, 16'h7bec);
    `CHK("retime", 1'b1, u_led_ctrl_model.retime_ok);
    t_sleep();
    t_current_set_resistor_pin();
    complete_run();
  end
endmodule
